/* File: logic/dhso_pkg.sv */
package dhso_pkg;
  // register byte addresses
  localparam logic [5:0] DEV_OPT_ADDR = 6'h00;
  localparam logic [5:0] HW_INFO_CNT_ADDR = 6'h04;
  localparam logic [5:0] EEPROM_SIZE_ADDR = 6'h08;
  localparam logic [5:0] HW_CFG_CNT_ADDR = 6'h0C;
  localparam logic [5:0] HW_CFG_WORD_ADDR = 6'h10;
  localparam logic [5:0] OP_COND_CNT_ADDR = 6'h14;
  localparam logic [5:0] SUPPLY_MV_ADDR = 6'h18;
  localparam logic [5:0] LOGIC_MV_ADDR = 6'h1C;
  localparam logic [5:0] BOARD_TEMP_ADDR = 6'h20;
  localparam logic [5:0] MOTOR_TEMP_ADDR = 6'h24;
  localparam logic [5:0] CHIP_TEMP_ADDR = 6'h28;
  localparam logic [5:0] SPEC_CNT_ADDR = 6'h2C;
  localparam logic [5:0] SPEC_SWITCH_ADDR = 6'h30;
  localparam logic [5:0] VIRT_SWITCH_ADDR = 6'h34;
  // reset values
  localparam logic [15:0] DEV_OPT_RST = 16'hFFFF;
  localparam logic [7:0] HW_INFO_CNT_RST = 8'h01;
  localparam logic [7:0] HW_CFG_CNT_RST = 8'h01;
  localparam logic [7:0] OP_COND_CNT_RST = 8'h05;
  localparam logic [7:0] SPEC_CNT_RST = 8'h02;
  localparam logic [31:0] HW_CFG_WORD_RST = 32'h0000_0000;
  localparam logic [7:0] SPEC_SWITCH_RST = 8'h00;
  localparam logic [7:0] VIRT_SWITCH_RST = 8'h00;
  // reaction codes
  localparam logic [15:0] REACT_NONE = 16'hFFFF;
  localparam logic [15:0] REACT_IMMEDIATE = 16'h0000;
  localparam logic [15:0] REACT_SLOW_RAMP = 16'h0001;
  localparam logic [15:0] REACT_QUICK_RAMP = 16'h0002;
  // special mode switch codes
  localparam logic [7:0] SPEC_OFF = 8'h00;
  localparam logic [7:0] SPEC_ON = 8'h02;

  typedef enum logic [3:0] {
    DHSO_ACT_NONE = 4'b0001,
    DHSO_ACT_STOP = 4'b0010,
    DHSO_ACT_SLOW = 4'b0100,
    DHSO_ACT_QUICK = 4'b1000
  } dhso_action_t;

  typedef struct packed {
    logic signed [31:0] supply_mv;
    logic signed [31:0] logic_mv;
    logic signed [31:0] board_temp;
    logic signed [31:0] motor_temp;
    logic signed [31:0] chip_temp;
  } dhso_sense_t;

  typedef struct packed {
    logic stop;
    logic slow_ramp;
    logic quick_ramp;
  } dhso_brake_t;
endpackage : dhso_pkg

/* File: logic/dhso_reaction.sv */
`timescale 1ns/10ps
module dhso_reaction (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_code,
  input wire logic i_dev_err,
  output dhso_pkg::dhso_brake_t o_brake,
  output logic o_invalid
);
  dhso_pkg::dhso_action_t act;

  always_comb begin
    unique case (i_code)
      dhso_pkg::REACT_NONE: act = dhso_pkg::DHSO_ACT_NONE;
      dhso_pkg::REACT_IMMEDIATE: act = dhso_pkg::DHSO_ACT_STOP;
      dhso_pkg::REACT_SLOW_RAMP: act = dhso_pkg::DHSO_ACT_SLOW;
      dhso_pkg::REACT_QUICK_RAMP: act = dhso_pkg::DHSO_ACT_QUICK;
      default: act = dhso_pkg::DHSO_ACT_NONE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_brake <= '0;
    end else begin
      o_brake.stop <= i_dev_err && (act == dhso_pkg::DHSO_ACT_STOP);
      o_brake.slow_ramp <= i_dev_err && (act == dhso_pkg::DHSO_ACT_SLOW);
      o_brake.quick_ramp <= i_dev_err && (act == dhso_pkg::DHSO_ACT_QUICK);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_invalid <= 1'b0;
    end else begin
      o_invalid <= !(i_code == dhso_pkg::REACT_NONE || i_code == dhso_pkg::REACT_IMMEDIATE
        || i_code == dhso_pkg::REACT_SLOW_RAMP || i_code == dhso_pkg::REACT_QUICK_RAMP);
    end
  end

  reserved_quiet_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_invalid |-> o_brake == '0) else $error("brake active for reserved code");
endmodule : dhso_reaction

/* File: logic/dhso_top.sv */
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module dhso_top (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [1:0] o_avs_response,
  input wire logic i_eeprom_present,
  input wire logic [31:0] i_eeprom_bytes,
  input wire dhso_pkg::dhso_sense_t i_sense,
  input wire logic i_following_err,
  input wire logic i_slip_err,
  output dhso_pkg::dhso_brake_t o_brake,
  output logic o_code_invalid,
  output logic o_spec_enable,
  output logic [7:0] o_spec_mode,
  output logic [31:0] o_hw_config
);
  logic rst_s1_q;
  logic rst_q;
  logic eep_p1_q, eep_p_q;
  logic [31:0] eep_b1_q, eep_b_q;
  dhso_pkg::dhso_sense_t sense1_q, sense_q;
  logic [1:0] err1_q, err_q;
  logic [15:0] dev_opt_q;
  logic [31:0] hw_cfg_q;
  logic [7:0] spec_sw_q;
  logic [7:0] virt_sw_q;
  logic ack_q;
  logic [31:0] rdata_d;
  logic hit_d;
  logic [31:0] bmask;
  logic wr_go;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  // pin inputs through two stages
  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      eep_p1_q <= 1'b0;
      eep_p_q <= 1'b0;
      eep_b1_q <= '0;
      eep_b_q <= '0;
      sense1_q <= '0;
      sense_q <= '0;
      err1_q <= '0;
      err_q <= '0;
    end else begin
      eep_p1_q <= i_eeprom_present;
      eep_p_q <= eep_p1_q;
      eep_b1_q <= i_eeprom_bytes;
      eep_b_q <= eep_b1_q;
      sense1_q <= i_sense;
      sense_q <= sense1_q;
      err1_q <= {i_slip_err, i_following_err};
      err_q <= err1_q;
    end
  end

  // one-cycle waitrequest then ack
  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end

  assign wr_go = i_avs_write && ack_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign bmask[gi*8 +: 8] = {8{i_avs_byteenable[gi]}};
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      dev_opt_q <= dhso_pkg::DEV_OPT_RST;
      hw_cfg_q <= dhso_pkg::HW_CFG_WORD_RST;
      spec_sw_q <= dhso_pkg::SPEC_SWITCH_RST;
      virt_sw_q <= dhso_pkg::VIRT_SWITCH_RST;
    end else if (wr_go) begin
      unique case (i_avs_address)
        dhso_pkg::DEV_OPT_ADDR:
          dev_opt_q <= (dev_opt_q & ~bmask[15:0]) | (i_avs_writedata[15:0] & bmask[15:0]);
        dhso_pkg::HW_CFG_WORD_ADDR:
          hw_cfg_q <= (hw_cfg_q & ~bmask) | (i_avs_writedata & bmask);
        dhso_pkg::SPEC_SWITCH_ADDR: begin
          if (i_avs_byteenable[0]) begin
            spec_sw_q <= i_avs_writedata[7:0];
          end
        end
        dhso_pkg::VIRT_SWITCH_ADDR: begin
          if (i_avs_byteenable[0]) begin
            virt_sw_q <= i_avs_writedata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rdata_d = '0;
    hit_d = 1'b1;
    unique case (i_avs_address)
      dhso_pkg::DEV_OPT_ADDR: rdata_d = {{16{dev_opt_q[15]}}, dev_opt_q};
      dhso_pkg::HW_INFO_CNT_ADDR: rdata_d = {24'h000000, dhso_pkg::HW_INFO_CNT_RST};
      dhso_pkg::EEPROM_SIZE_ADDR: rdata_d = eep_p_q ? eep_b_q : 32'h0000_0000;
      dhso_pkg::HW_CFG_CNT_ADDR: rdata_d = {24'h000000, dhso_pkg::HW_CFG_CNT_RST};
      dhso_pkg::HW_CFG_WORD_ADDR: rdata_d = hw_cfg_q;
      dhso_pkg::OP_COND_CNT_ADDR: rdata_d = {24'h000000, dhso_pkg::OP_COND_CNT_RST};
      dhso_pkg::SUPPLY_MV_ADDR: rdata_d = sense_q.supply_mv;
      dhso_pkg::LOGIC_MV_ADDR: rdata_d = sense_q.logic_mv;
      dhso_pkg::BOARD_TEMP_ADDR: rdata_d = sense_q.board_temp;
      dhso_pkg::MOTOR_TEMP_ADDR: rdata_d = sense_q.motor_temp;
      dhso_pkg::CHIP_TEMP_ADDR: rdata_d = sense_q.chip_temp;
      dhso_pkg::SPEC_CNT_ADDR: rdata_d = {24'h000000, dhso_pkg::SPEC_CNT_RST};
      dhso_pkg::SPEC_SWITCH_ADDR: rdata_d = {24'h000000, spec_sw_q};
      dhso_pkg::VIRT_SWITCH_ADDR: rdata_d = {24'h000000, virt_sw_q};
      default: hit_d = 1'b0;
    endcase
  end

  // waitrequest high until answer
  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !ack_q);
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      o_avs_readdata <= '0;
      o_avs_response <= 2'h0;
    end else if ((i_avs_read || i_avs_write) && !ack_q) begin
      o_avs_readdata <= i_avs_read ? rdata_d : 32'h0000_0000;
      o_avs_response <= hit_d ? 2'h0 : 2'h3;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      o_spec_enable <= 1'b0;
      o_spec_mode <= '0;
    end else begin
      o_spec_enable <= spec_sw_q == dhso_pkg::SPEC_ON;
      o_spec_mode <= (spec_sw_q == dhso_pkg::SPEC_ON) ? virt_sw_q : 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk or negedge rst_q) begin
    if (!rst_q) begin
      o_hw_config <= dhso_pkg::HW_CFG_WORD_RST;
    end else begin
      o_hw_config <= hw_cfg_q;
    end
  end

  dhso_reaction u_react (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_q),
    .i_code(dev_opt_q),
    .i_dev_err(err_q[0] || err_q[1]),
    .o_brake(o_brake),
    .o_invalid(o_code_invalid)
  );

  spec_off_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    $past(spec_sw_q) == dhso_pkg::SPEC_OFF |-> !o_spec_enable)
    else $error("special modes enabled while switched off");

  spec_on_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    spec_sw_q == dhso_pkg::SPEC_ON |=> o_spec_enable && o_spec_mode == $past(virt_sw_q))
    else $error("special mode not taken from virtual switch");

  quick_brake_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (dev_opt_q == dhso_pkg::REACT_QUICK_RAMP && (err_q != 2'b00)) |=> o_brake.quick_ramp)
    else $error("quick ramp not applied");

  stop_brake_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (dev_opt_q == dhso_pkg::REACT_IMMEDIATE && err_q[1]) |=> o_brake.stop && !o_brake.slow_ramp)
    else $error("immediate stop not applied");

  idle_brake_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    err_q == 2'b00 |=> o_brake == '0) else $error("brake without deviation error");

  ro_write_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (wr_go && i_avs_address == dhso_pkg::EEPROM_SIZE_ADDR) |=> $stable(spec_sw_q)
    && $stable(hw_cfg_q) && $stable(dev_opt_q)) else $error("read-only write changed state");

  eep_zero_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (!eep_p_q && i_avs_read && !ack_q && i_avs_address == dhso_pkg::EEPROM_SIZE_ADDR)
    |=> o_avs_readdata == 32'h0000_0000) else $error("eeprom size nonzero when absent");

  supply_rd_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (i_avs_read && !ack_q && i_avs_address == dhso_pkg::SUPPLY_MV_ADDR)
    |=> o_avs_readdata == $past(sense_q.supply_mv)) else $error("supply readout wrong");

  slow_brake_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (dev_opt_q == dhso_pkg::REACT_SLOW_RAMP && (err_q != 2'b00))
    |=> o_brake.slow_ramp && !o_brake.stop && !o_brake.quick_ramp)
    else $error("slow ramp not applied");

  none_brake_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    dev_opt_q == dhso_pkg::REACT_NONE |=> o_brake == '0)
    else $error("brake for no-reaction code");

  reserved_flag_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    !(dev_opt_q == dhso_pkg::REACT_NONE || dev_opt_q == dhso_pkg::REACT_IMMEDIATE
    || dev_opt_q == dhso_pkg::REACT_SLOW_RAMP || dev_opt_q == dhso_pkg::REACT_QUICK_RAMP)
    |=> o_code_invalid && o_brake == '0) else $error("reserved code not refused");

  eep_size_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (eep_p_q && i_avs_read && !ack_q && i_avs_address == dhso_pkg::EEPROM_SIZE_ADDR)
    |=> o_avs_readdata == $past(eep_b_q)) else $error("eeprom size readout wrong");

  logic_rd_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (i_avs_read && !ack_q && i_avs_address == dhso_pkg::LOGIC_MV_ADDR)
    |=> o_avs_readdata == $past(sense_q.logic_mv)) else $error("logic readout wrong");

  board_rd_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (i_avs_read && !ack_q && i_avs_address == dhso_pkg::BOARD_TEMP_ADDR)
    |=> o_avs_readdata == $past(sense_q.board_temp)) else $error("board readout wrong");

  ro_hold_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (wr_go && i_avs_address != dhso_pkg::DEV_OPT_ADDR
    && i_avs_address != dhso_pkg::HW_CFG_WORD_ADDR
    && i_avs_address != dhso_pkg::SPEC_SWITCH_ADDR
    && i_avs_address != dhso_pkg::VIRT_SWITCH_ADDR)
    |=> $stable(dev_opt_q) && $stable(hw_cfg_q) && $stable(spec_sw_q) && $stable(virt_sw_q))
    else $error("write outside rw entries changed state");

  cnt_rd_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    (i_avs_read && !ack_q && i_avs_address == dhso_pkg::OP_COND_CNT_ADDR)
    |=> o_avs_readdata == {24'h000000, dhso_pkg::OP_COND_CNT_RST})
    else $error("entry count readout wrong");

  spec_idle_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    spec_sw_q != dhso_pkg::SPEC_ON |=> !o_spec_enable && o_spec_mode == 8'h00)
    else $error("special mode active while not switched on");

  // answer one cycle after request
  wait_low_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    ((i_avs_read || i_avs_write) && !ack_q) |=> !o_avs_waitrequest)
    else $error("no answer one cycle after request");

  // answer stands one cycle
  wait_high_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // unmapped address refused
  decode_err_a: assert property (@(posedge i_ref_clk) disable iff (!rst_q)
    ((i_avs_read || i_avs_write) && !ack_q && !hit_d) |=> o_avs_response == 2'h3)
    else $error("unmapped address not refused");
endmodule : dhso_top

/* File: testbench/dhso_top_tb.sv */
`timescale 1ns/10ps
module dhso_top_tb;
  logic i_ref_clk;
  logic i_resetn;
  logic [5:0] i_avs_address;
  logic i_avs_read;
  logic i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0] i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic [1:0] o_avs_response;
  logic i_eeprom_present;
  logic [31:0] i_eeprom_bytes;
  dhso_pkg::dhso_sense_t i_sense;
  logic i_following_err;
  logic i_slip_err;
  dhso_pkg::dhso_brake_t o_brake;
  logic o_code_invalid;
  logic o_spec_enable;
  logic [7:0] o_spec_mode;
  logic [31:0] o_hw_config;
  int mismatches;
  int checks;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [5:0] ra [14] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20,
                         6'h24, 6'h28, 6'h2C, 6'h30, 6'h34};
  logic [31:0] rv [14] = '{32'hFFFFFFFF, 32'h01, 32'h00, 32'h01, 32'h00, 32'h05, 32'h5DC0,
                          32'h12C0, 32'hFFFFFF83, 32'h12C, 32'h1F4, 32'h02, 32'h00, 32'h00};
  logic [5:0] wo [10] = '{6'h04, 6'h08, 6'h0C, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24, 6'h28,
                         6'h2C};
  logic [15:0] codes [7] = '{16'hFFFF, 16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h7FFF, 16'h8000};
  logic [3:0] expb [7] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1, 4'h1, 4'h1};
  logic [7:0] offv [3] = '{8'h00, 8'h01, 8'h03};

  dhso_top dut (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
    .i_eeprom_present(i_eeprom_present), .i_eeprom_bytes(i_eeprom_bytes), .i_sense(i_sense),
    .i_following_err(i_following_err), .i_slip_err(i_slip_err), .o_brake(o_brake),
    .o_code_invalid(o_code_invalid), .o_spec_enable(o_spec_enable), .o_spec_mode(o_spec_mode),
    .o_hw_config(o_hw_config)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one bus cycle, held until waitrequest is sampled low
  task automatic access(input logic wr, input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] be);
    int n;
    n = 0;
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_byteenable <= be;
    i_avs_read <= !wr;
    i_avs_write <= wr;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("[ERR] %0t no answer at %h", $time, a);
    end
    rd = o_avs_readdata;
    rsp = o_avs_response;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
    @(posedge i_ref_clk);
  endtask : access

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    access(1'b0, a, 32'h0, 4'hF);
    chk(rd, exp);
    chk({30'h0, rsp}, 32'h0);
  endtask : rd_chk

  task automatic check_all;
    for (int i = 0; i < 14; i++) begin
      rd_chk(ra[i], rv[i]);
    end
  endtask : check_all

  initial begin
    repeat (20000) @(posedge i_ref_clk);
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    mismatches = 0;
    checks = 0;
    i_resetn = 1'b0;
    i_avs_address = 6'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    i_eeprom_present = 1'b0;
    i_eeprom_bytes = 32'h00008000;
    i_sense = {32'h00005DC0, 32'h000012C0, 32'hFFFFFF83, 32'h0000012C, 32'h000001F4};
    i_following_err = 1'b0;
    i_slip_err = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    check_all();
    foreach (wo[i]) access(1'b1, wo[i], 32'hA5A5A5A5, 4'hF);
    check_all();
    i_eeprom_present <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    rd_chk(6'h08, 32'h00008000);
    // unmapped place answers decode error
    access(1'b1, 6'h3C, 32'h1, 4'hF);
    chk({30'h0, rsp}, 32'h3);
    access(1'b0, 6'h3C, 32'h0, 4'hF);
    chk({30'h0, rsp}, 32'h3);
    access(1'b1, 6'h10, 32'h12345678, 4'hF);
    access(1'b1, 6'h10, 32'hFFFFFFFF, 4'h2);
    rd_chk(6'h10, 32'h1234FF78);
    chk(o_hw_config, 32'h1234FF78);
    for (int i = 0; i < 7; i++) begin
      access(1'b1, 6'h00, {16'h0, codes[i]}, 4'h3);
      rd_chk(6'h00, {{16{codes[i][15]}}, codes[i]});
      if (i % 2 == 1) begin
        i_slip_err <= 1'b1;
      end else begin
        i_following_err <= 1'b1;
      end
      repeat (5) @(posedge i_ref_clk);
      chk({28'h0, o_brake, o_code_invalid}, {28'h0, expb[i]});
      i_following_err <= 1'b0;
      i_slip_err <= 1'b0;
      repeat (5) @(posedge i_ref_clk);
      chk({29'h0, o_brake}, 32'h0);
    end
    access(1'b1, 6'h34, 32'h05, 4'h1);
    access(1'b1, 6'h30, 32'h02, 4'h1);
    repeat (2) @(posedge i_ref_clk);
    chk({23'h0, o_spec_enable, o_spec_mode}, 32'h105);
    foreach (offv[i]) begin
      access(1'b1, 6'h30, {24'h0, offv[i]}, 4'h1);
      rd_chk(6'h30, {24'h0, offv[i]});
      repeat (2) @(posedge i_ref_clk);
      chk({23'h0, o_spec_enable, o_spec_mode}, 32'h0);
    end
    // mid-run reset restores rw entries
    i_eeprom_present <= 1'b0;
    i_resetn <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    check_all();
    close_out();
  end
endmodule : dhso_top_tb
